// >>> verilog/rcs_host.v
`timescale 1ns/10ps
`include "rcs_consts.vh"
module rcs_host #(
  parameter ADDR_W = `RCS_ADDR_W,
  parameter WE_CYC = `RCS_WE_CYC
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire req_i,
  input wire wr_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire wdata_i,
  input wire mem_dout_i,
  output reg busy_o,
  output reg done_o,
  output reg rdata_o,
  output reg [`RCS_CELL_W-1:0] mem_addr_o,
  output reg [`RCS_NDEC-1:0] mem_cs1_o,
  output reg [`RCS_NDEC-1:0] mem_cs2_o,
  output reg mem_we_o,
  output reg mem_din_o
);
  // ======================================
  // states
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_WR = 4'h2;
  localparam [3:0] S_RD = 4'h4;
  localparam [3:0] S_END = 4'h8;
  // a zero setting still gives one cycle of write or read time
  localparam integer CNT_LAST_I = (WE_CYC > 1) ? (WE_CYC - 1) : 0;
  localparam [7:0] CNT_LAST = CNT_LAST_I[7:0];

  // ======================================
  // registers and next values
  reg [3:0] state;
  reg [7:0] cnt;
  reg [3:0] next_state;
  reg [7:0] next_cnt;
  reg next_busy;
  reg next_done;
  reg next_rdata;
  reg [`RCS_CELL_W-1:0] next_addr;
  reg [`RCS_NDEC-1:0] next_cs1;
  reg [`RCS_NDEC-1:0] next_cs2;
  reg next_we;
  reg next_din;
  wire idle_req;
  wire [`RCS_NDEC-1:0] dec1;
  wire [`RCS_NDEC-1:0] dec2;

  // ======================================
  // phase end test, shared by the write and read phases
  function at_last;
    input [7:0] c;
    begin
      at_last = (c >= CNT_LAST);
    end
  endfunction

  // ======================================
  // coincident select: two one-of-eight decoders
  assign idle_req = req_i && (state == S_IDLE);

  rcs_decoder #(.SEL_W(`RCS_SEL_W), .N(`RCS_NDEC)) u_dec1 (
    .sel_i(addr_i[`RCS_SEL1_LSB +: `RCS_SEL_W]),
    .en_i(idle_req),
    .line_o(dec1)
  );

  rcs_decoder #(.SEL_W(`RCS_SEL_W), .N(`RCS_NDEC)) u_dec2 (
    .sel_i(addr_i[`RCS_SEL2_LSB +: `RCS_SEL_W]),
    .en_i(idle_req),
    .line_o(dec2)
  );

  // ======================================
  // next-value logic; no refresh state exists since storage is static
  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_busy = busy_o;
    next_done = 1'h0;
    next_rdata = rdata_o;
    next_addr = mem_addr_o;
    next_cs1 = mem_cs1_o;
    next_cs2 = mem_cs2_o;
    next_we = mem_we_o;
    next_din = mem_din_o;
    case (state)
      S_IDLE: begin
        if (req_i) begin
          next_busy = 1'h1;
          next_addr = addr_i[`RCS_CELL_LSB +: `RCS_CELL_W];
          next_cs1 = dec1;
          next_cs2 = dec2;
          next_din = wdata_i;
          next_we = wr_i;
          next_cnt = 8'h00;
          if (wr_i) begin
            next_state = S_WR;
          end else begin
            next_state = S_RD;
          end
        end
      end
      S_WR: begin
        // we held for the full write time; selects outlast it a cycle, the address holds until the next access
        if (at_last(cnt)) begin
          next_we = 1'h0;
          next_state = S_END;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      S_RD: begin
        // we stays low; sample once the access time has passed
        if (at_last(cnt)) begin
          next_rdata = mem_dout_i;
          next_state = S_END;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      S_END: begin
        next_cs1 = `RCS_CS1_RST;
        next_cs2 = `RCS_CS2_RST;
        next_busy = 1'h0;
        next_done = 1'h1;
        next_state = S_IDLE;
      end
      default: begin
        // lost state: drop every select rather than risk a stray write
        next_we = 1'h0;
        next_cs1 = `RCS_CS1_RST;
        next_cs2 = `RCS_CS2_RST;
        next_busy = 1'h0;
        next_state = S_IDLE;
      end
    endcase
  end

  // ======================================
  // state registers; a low enable freezes everything
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
    end else if (ce_i) begin
      cnt <= next_cnt;
    end
  end

  // ======================================
  // host-side outputs
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'h0;
    end else if (ce_i) begin
      busy_o <= next_busy;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'h0;
    end else if (ce_i) begin
      done_o <= next_done;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 1'h0;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
    end
  end

  // ======================================
  // array-side outputs
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr_o <= 8'h00;
    end else if (ce_i) begin
      mem_addr_o <= next_addr;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_cs1_o <= `RCS_CS1_RST;
    end else if (ce_i) begin
      mem_cs1_o <= next_cs1;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_cs2_o <= `RCS_CS2_RST;
    end else if (ce_i) begin
      mem_cs2_o <= next_cs2;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_we_o <= 1'h0;
    end else if (ce_i) begin
      mem_we_o <= next_we;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_din_o <= 1'h0;
    end else if (ce_i) begin
      mem_din_o <= next_din;
    end
  end
endmodule // rcs_host

// >>> verilog/rcs_consts.vh
// Functional notes
// - write-enable level chosen per access decides write versus read.
// - controller drives fourteen address bits across sixty-four devices.
// - low eight address bits go to every device in parallel.
// - device responds only when both its chip selects are active.
// - two three-bit fields feed two one-of-eight chip-select decoders.
`ifndef RCS_CONSTS_VH
`define RCS_CONSTS_VH
// ======================================
// address layout
`define RCS_ADDR_W 14
`define RCS_CELL_W 8
`define RCS_CELL_LSB 0
`define RCS_SEL1_LSB 8
`define RCS_SEL2_LSB 11
`define RCS_SEL_W 3
`define RCS_NDEC 8
// ======================================
// timing
`define RCS_CLK_NS 100
`define RCS_WE_NS 100
`define RCS_WE_CYC (((`RCS_WE_NS) + (`RCS_CLK_NS) - 1) / (`RCS_CLK_NS))
`define RCS_CS1_RST 8'h00
`define RCS_CS2_RST 8'h00
`endif

// >>> verilog/rcs_decoder.v
`timescale 1ns/10ps
`include "rcs_consts.vh"
module rcs_decoder #(
  parameter SEL_W = `RCS_SEL_W,
  parameter N = `RCS_NDEC
) (
  input wire [SEL_W-1:0] sel_i,
  input wire en_i,
  output wire [N-1:0] line_o
);
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_line
      localparam integer IDX = g;
      assign line_o[g] = en_i && (sel_i == IDX[SEL_W-1:0]);
    end
  endgenerate
endmodule // rcs_decoder

// >>> verification/rcs_ram_model.sv
`timescale 1ns/10ps
module rcs_ram_model (
  input wire logic [7:0] a_i,
  input wire logic [7:0] cs1_i,
  input wire logic [7:0] cs2_i,
  input wire logic we_i,
  input wire logic din_i,
  output logic dout_o
);
  // ======================================
  // 64 static devices of 256 x 1, no refresh
  logic m [0:16383];
  logic [5:0] dev;
  logic hit;
  always_comb begin
    hit = 1'h0;
    dev = 6'h00;
    for (int i = 0; i < 64; i++) begin
      if (cs1_i[i % 8] && cs2_i[i / 8]) begin
        hit = 1'h1;
        dev = i[5:0];
      end
    end
  end
  // ======================================
  // cell takes data as the write pulse ends, so same-step glitches cannot write
  always @(negedge we_i) begin
    if (hit) begin
      m[{dev, a_i}] <= din_i;
    end
  end
  // unselected: inverse of device 0's cell at a_i, never a stale match
  assign dout_o = hit ? m[{dev, a_i}] : ~m[{dev, a_i}];
endmodule // rcs_ram_model

// >>> verification/rcs_host_checker.sv
`timescale 1ns/10ps
module rcs_host_checker (
  input wire ref_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire req_i,
  input wire wr_i,
  input wire wdata_i,
  input wire [13:0] addr_i,
  input wire busy_o,
  input wire done_o,
  input wire mem_we_o,
  input wire mem_din_o,
  input wire [7:0] mem_addr_o,
  input wire [7:0] mem_cs1_o,
  input wire [7:0] mem_cs2_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence take;
    ce_i && req_i && !busy_o;
  endsequence
  sequence wr_take;
    take ##0 wr_i;
  endsequence
  sequence rd_take;
    take ##0 !wr_i;
  endsequence
  chk_write_data: assert property (wr_take |=> mem_din_o == $past(wdata_i))
    else $error("write data mismatch");
  chk_read_nowrite: assert property (rd_take |=> (!mem_we_o) [*2])
    else $error("write enable during read");
  chk_done_release: assert property (done_o |->
    !busy_o && mem_cs1_o == 8'h00 && mem_cs2_o == 8'h00)
    else $error("selects held after done");
  chk_mode_level: assert property (take |=> mem_we_o == $past(wr_i))
    else $error("write enable mismatch");
  chk_cell_addr: assert property (take |=> mem_addr_o == $past(addr_i[7:0]))
    else $error("cell address mismatch");
  chk_decode_fields: assert property (take |=>
    mem_cs1_o == 8'h01 << $past(addr_i[10:8]) && mem_cs2_o == 8'h01 << $past(addr_i[13:11]))
    else $error("select decode mismatch");
  chk_select_pair: assert property ($onehot0(mem_cs1_o) &&
    $onehot(mem_cs1_o) == $onehot(mem_cs2_o)) else $error("select pair mismatch");
  chk_write_sel: assert property (mem_we_o |-> busy_o && $onehot(mem_cs2_o))
    else $error("write without select");
endmodule // rcs_host_checker
bind rcs_host rcs_host_checker rcs_host_checker_i (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .req_i(req_i),
  .wr_i(wr_i),
  .wdata_i(wdata_i),
  .addr_i(addr_i),
  .busy_o(busy_o),
  .done_o(done_o),
  .mem_we_o(mem_we_o),
  .mem_din_o(mem_din_o),
  .mem_addr_o(mem_addr_o),
  .mem_cs1_o(mem_cs1_o),
  .mem_cs2_o(mem_cs2_o)
);

// >>> verification/rcs_host_tb.sv
`timescale 1ns/10ps
`include "rcs_consts.vh"
module rcs_host_tb;
  logic ref_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic ce_i = 1'h1;
  logic req_i = 1'h0;
  logic wr_i = 1'h0;
  logic wdata_i = 1'h0;
  logic [13:0] addr_i = 14'h0000;
  logic busy_o;
  logic done_o;
  logic rdata_o;
  logic mem_we_o;
  logic mem_din_o;
  logic mem_dout_i;
  logic [7:0] mem_addr_o;
  logic [7:0] mem_cs1_o;
  logic [7:0] mem_cs2_o;
  int mismatches = 0;
  int n_tests = 0;
  rcs_host rcs_host_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .req_i(req_i),
    .wr_i(wr_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .mem_dout_i(mem_dout_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .rdata_o(rdata_o),
    .mem_addr_o(mem_addr_o),
    .mem_cs1_o(mem_cs1_o),
    .mem_cs2_o(mem_cs2_o),
    .mem_we_o(mem_we_o),
    .mem_din_o(mem_din_o)
  );
  rcs_ram_model rcs_ram_model_i (
    .a_i(mem_addr_o),
    .cs1_i(mem_cs1_o),
    .cs2_i(mem_cs2_o),
    .we_i(mem_we_o),
    .din_i(mem_din_o),
    .dout_o(mem_dout_i)
  );
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task conclude;
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task fail(input string msg);
    mismatches++;
    $display("Error %0t %s", $time, msg);
  endtask
  task acc(input logic w, input logic [13:0] a, input logic d, input logic e);
    int k;
    @(negedge ref_clk_i);
    req_i = 1'h1;
    wr_i = w;
    addr_i = a;
    wdata_i = d;
    @(negedge ref_clk_i);
    req_i = 1'h0;
    n_tests++;
    if (busy_o !== 1'h1 || mem_we_o !== w) fail("access not started");
    for (k = 0; k < 9 && done_o !== 1'h1; k++) @(negedge ref_clk_i);
    n_tests++;
    if (k != `RCS_WE_CYC + 1 || busy_o !== 1'h0 || (!w && rdata_o !== e)) begin
      fail("access result");
      if (k == 9) conclude;
    end
  endtask
  // request held off while frozen, then an access frozen half way
  task t_freeze;
    int k;
    @(negedge ref_clk_i);
    ce_i = 1'h0;
    req_i = 1'h1;
    wr_i = 1'h0;
    addr_i = 14'h3fff;
    repeat (3) @(negedge ref_clk_i);
    n_tests++;
    if (busy_o !== 1'h0 || mem_cs1_o !== 8'h00) fail("taken while frozen");
    ce_i = 1'h1;
    @(negedge ref_clk_i);
    req_i = 1'h0;
    ce_i = 1'h0;
    repeat (4) @(negedge ref_clk_i);
    n_tests++;
    if (busy_o !== 1'h1 || done_o !== 1'h0) fail("frozen access moved");
    ce_i = 1'h1;
    for (k = 0; k < 9 && done_o !== 1'h1; k++) @(negedge ref_clk_i);
    n_tests++;
    if (k == 9 || rdata_o !== 1'h1) begin
      fail("frozen read");
      if (k == 9) conclude;
    end
  endtask
  // reset in mid-read: everything drops, then the store is still intact
  task t_reset;
    @(negedge ref_clk_i);
    req_i = 1'h1;
    wr_i = 1'h0;
    addr_i = 14'h0000;
    @(negedge ref_clk_i);
    req_i = 1'h0;
    rst_i = 1'h1;
    @(negedge ref_clk_i);
    n_tests++;
    if (busy_o !== 1'h0 || done_o !== 1'h0 || rdata_o !== 1'h0 || mem_we_o !== 1'h0 ||
        mem_cs1_o !== 8'h00 || mem_cs2_o !== 8'h00 || mem_addr_o !== 8'h00) begin
      fail("outputs not cleared by reset");
    end
    @(negedge ref_clk_i);
    rst_i = 1'h0;
    acc(0, 14'h0000, 0, 1);
  endtask
  // every device row and column once
  task t_spread;
    for (int i = 0; i < 8; i++) acc(1, {i[2:0], 3'(7 - i), 8'(i * 37)}, i[0], 0);
    for (int i = 0; i < 8; i++) acc(0, {i[2:0], 3'(7 - i), 8'(i * 37)}, 0, i[0]);
  endtask
  task t_reread;
    acc(1, 14'h3fff, 1, 0);
    acc(0, 14'h3fff, 0, 1);
    acc(0, 14'h3fff, 0, 1);
  endtask
  task t_flip;
    acc(1, 14'h0000, 0, 0);
    acc(1, 14'h0000, 1, 0);
    acc(0, 14'h0000, 0, 1);
  endtask
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_i = 0;
    t_spread;
    t_reread;
    t_flip;
    t_freeze;
    t_reset;
    conclude;
  end
endmodule // rcs_host_tb
